// file: design/cbco_pkg.sv
// Constants for the compare, branch and control order executor.
// Assumes a 32-bit APB master and a 52-bit word, bit n held at index n-1.
package cbco_pkg;

  localparam int WORD_W   = 52;
  localparam int ADDR_W   = 16;
  localparam int PADDR_W  = 8;
  localparam int MAX_SBUF = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ADDR_A  = 8'h04;
  localparam logic [7:0] OFS_ADDR_B  = 8'h08;
  localparam logic [7:0] OFS_ADDR_C  = 8'h0C;
  localparam logic [7:0] OFS_OSTB    = 8'h10;
  localparam logic [7:0] OFS_OPA_LO  = 8'h14;
  localparam logic [7:0] OFS_OPA_HI  = 8'h18;
  localparam logic [7:0] OFS_OPB_LO  = 8'h1C;
  localparam logic [7:0] OFS_OPB_HI  = 8'h20;
  localparam logic [7:0] OFS_SEQ     = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;
  localparam logic [7:0] OFS_SUBCALL = 8'h2C;
  localparam logic [7:0] OFS_SENT_LO = 8'h30;
  localparam logic [7:0] OFS_SENT_HI = 8'h34;
  localparam logic [7:0] OFS_SEARCH  = 8'h38;
  localparam logic [7:0] OFS_KEYSEL  = 8'h3C;
  localparam logic [7:0] OFS_KEY_LO  = 8'h40;
  localparam logic [7:0] OFS_KEY_HI  = 8'h44;

  // Field positions
  localparam int CTRL_START_BIT = 8;
  localparam int ST_BUSY        = 0;
  localparam int ST_HALTED      = 1;
  localparam int ST_KEY_WAIT    = 2;
  localparam int ST_BRANCHED    = 3;
  localparam int ST_SUB_VALID   = 4;
  localparam int ST_AT_FIRST    = 5;
  localparam int SUB_VALID_BIT  = 16;
  localparam int KEYSEL_KEY_BIT = 4;
  localparam int HI_W           = WORD_W - 32;
  localparam int MAG_W          = 44;
  localparam int SIGN_IDX       = 44;
  localparam int SENT_IDX       = 51;
  localparam int OSTB_W         = 13;
  localparam int OSTB_HALT      = 0;
  localparam int OSTB_PROCEED   = 1;
  localparam int OSTB_BRK_LSB   = 2;
  localparam int NUM_BRK        = 10;

  // Order word layout: op, A, B, C
  localparam int OP_LSB = 48;
  localparam int A_LSB  = 32;
  localparam int B_LSB  = 16;

  // Order codes
  localparam logic [3:0] OP_NO_OP          = 4'h0;
  localparam logic [3:0] OP_NUMERIC_LE     = 4'h1;
  localparam logic [3:0] OP_NUMERIC_NE     = 4'h2;
  localparam logic [3:0] OP_ALPHA_LE       = 4'h3;
  localparam logic [3:0] OP_ALPHA_NE       = 4'h4;
  localparam logic [3:0] OP_FIRST_KEY      = 4'h5;
  localparam logic [3:0] OP_SECOND_KEY     = 4'h6;
  localparam logic [3:0] OP_PRINT_ALPHA    = 4'h7;
  localparam logic [3:0] OP_PRINT_NUMERIC  = 4'h8;
  localparam logic [3:0] OP_COND_HALT      = 4'h9;
  localparam logic [3:0] OP_JUMP_SUBCALL   = 4'hA;
  localparam logic [3:0] OP_BRANCH_RETURN  = 4'hB;
  localparam logic [3:0] OP_TAPE_REWIND    = 4'hC;

  // Console optional-stop switch
  localparam logic [1:0] SW_STOP    = 2'h0;
  localparam logic [1:0] SW_PROCEED = 2'h1;
  localparam logic [1:0] SW_COMPARE = 2'h2;

  localparam logic [ADDR_W-1:0] ADDR_VOID     = 16'h0000;
  localparam logic [ADDR_W-1:0] SENT_REG_ADDR = 16'h1997;
  localparam logic [ADDR_W-1:0] SEQ_RST       = 16'h0000;
  localparam logic [WORD_W-1:0] PASS_WORD     = {OP_NO_OP, 48'h0000_0000_0000};

endpackage

// file: design/cbco_cmp.sv
// Numeric and alphabetic word comparator.
// Assumes BCD magnitude in bits 1..44, sign in bit 45, collating codes ascending.
`timescale 1ns/1ps
module cbco_cmp (
  input  wire logic [cbco_pkg::WORD_W-1:0] word_a,
  input  wire logic [cbco_pkg::WORD_W-1:0] word_b,
  output logic                             num_lt,
  output logic                             num_eq,
  output logic                             alp_lt,
  output logic                             alp_eq
);
  import cbco_pkg::*;

  logic [MAG_W-1:0] mag_a;
  logic [MAG_W-1:0] mag_b;
  logic             neg_a;
  logic             neg_b;

  // Bits 49..51 never reach the numeric path
  assign mag_a = word_a[MAG_W-1:0];
  assign mag_b = word_b[MAG_W-1:0];
  // A zero magnitude is never negative, so +0 equals -0
  assign neg_a = word_a[SIGN_IDX] && (mag_a != '0);
  assign neg_b = word_b[SIGN_IDX] && (mag_b != '0);

  always_comb begin
    num_eq = (neg_a == neg_b) && (mag_a == mag_b);
    num_lt = (neg_a && !neg_b) || (!neg_a && !neg_b && (mag_a < mag_b)) || (neg_a && neg_b && (mag_a > mag_b));
  end

  // Whole word including sign and bits 49..51; digit codes sit below letter codes
  assign alp_eq = (word_a == word_b);
  assign alp_lt = (word_a < word_b);

endmodule // cbco_cmp

// file: design/cbco_exec.sv
// Executor for comparison, key comparison, print and control orders, APB slave.
// Assumes synchronous console inputs and software-fed operands and search keys.
//
// Overview of operation
// - Rewind leaves unit at first block
// - Numeric compare algebraic, plus zero equals minus
// - Numeric less-or-equal loads sequence with C
// - Numeric inequality loads sequence with C
// - Alphabetic: signed zeros differ, digits before letters
// - Alphabetic less-or-equal branches to C
// - Alphabetic inequality branches on any bit difference
// - Key compare copies buffered key into A
// - Stall only while same buffer search pending
// - Unfilled unsearched buffer: no copy, no stall
// - Sentinel or pass order into register 1997
// - First key branches when at least B
// - Second key branches when at most B
// - Numeric ignores bits 49-51, alphabetic keeps
// - Print A; optional sequence change and subcall
// - Pass just takes next order
// - Optional stop: forced halt or switch
// - Compare mode halts on matching breakpoint
// - Start subcalls C; set-up then start resumes
// - Encoded bits 17, 18, 19-28 control stop
// - Sequence change: sequence gets B, subcall C
// - Branch-return stores restore order into A
`timescale 1ns/1ps
module cbco_exec #(
  parameter int NUM_SBUF = 10
) (
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cbco_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [1:0]                    stop_switch,
  input  wire logic [cbco_pkg::NUM_BRK-1:0]  brk_switch,
  input  wire logic                          start_button,
  input  wire logic                          setup_button,
  output logic                               halted,
  output logic                               print_valid,
  output logic                               print_alpha,
  output logic [cbco_pkg::WORD_W-1:0]        print_word,
  output logic                               rewind_valid,
  output logic [7:0]                         rewind_unit
);
  import cbco_pkg::*;

  if (NUM_SBUF < 1 || NUM_SBUF > MAX_SBUF) begin : g_bad_sbuf
    $error("NUM_SBUF out of range");
  end

  typedef enum logic [2:0] {S_IDLE, S_EXEC, S_KWAIT, S_KCMP, S_HALT} cbco_state_e;

  typedef struct packed {
    cbco_state_e                             st;
    logic                                    pready;
    logic                                    pslverr;
    logic [31:0]                             prdata;
    logic [3:0]                              op;
    logic [ADDR_W-1:0]                       addr_a;
    logic [ADDR_W-1:0]                       addr_b;
    logic [ADDR_W-1:0]                       addr_c;
    logic [OSTB_W-1:0]                       ostb;
    logic [WORD_W-1:0]                       opa;
    logic [WORD_W-1:0]                       opb;
    logic [ADDR_W-1:0]                       seq;
    logic [WORD_W-1:0]                       sent;
    logic [ADDR_W-1:0]                       sub_addr;
    logic                                    sub_vld;
    logic                                    branched;
    logic [4:0]                              keysel;
    logic [NUM_SBUF-1:0][1:0][WORD_W-1:0]    keys;
    logic [NUM_SBUF-1:0]                     filled;
    logic [NUM_SBUF-1:0]                     pending;
    logic                                    setup_seen;
    logic                                    start_prev;
    logic                                    setup_prev;
    logic                                    at_first;
    logic                                    halted;
    logic                                    print_vld;
    logic                                    print_alpha;
    logic [WORD_W-1:0]                       print_word;
    logic                                    rewind_vld;
    logic [7:0]                              rewind_unit;
  } cbco_reg_s;

  cbco_reg_s q;
  cbco_reg_s d;

  logic num_lt;
  logic num_eq;
  logic alp_lt;
  logic alp_eq;

  cbco_cmp u_cmp (
    .word_a (q.opa),
    .word_b (q.opb),
    .num_lt (num_lt),
    .num_eq (num_eq),
    .alp_lt (alp_lt),
    .alp_eq (alp_eq)
  );

  logic [3:0]  buf_idx;
  logic        buf_ok;
  logic [3:0]  ksel_idx;
  logic        ksel_ok;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] rd_word;
  logic        take;
  logic        stop_now;
  logic        start_rise;
  logic        setup_rise;

  assign buf_idx    = q.addr_a[3:0];
  assign buf_ok     = (32'(buf_idx) < NUM_SBUF);
  assign ksel_idx   = q.keysel[3:0];
  assign ksel_ok    = (32'(ksel_idx) < NUM_SBUF);
  assign wr_en      = psel && penable && q.pready && pwrite;
  assign rd_en      = psel && penable && q.pready && !pwrite;
  assign start_rise = start_button && !q.start_prev;
  assign setup_rise = setup_button && !q.setup_prev;

  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:    rd_word = {28'h000_0000, q.op};
      OFS_ADDR_A:  rd_word = {16'h0000, q.addr_a};
      OFS_ADDR_B:  rd_word = {16'h0000, q.addr_b};
      OFS_ADDR_C:  rd_word = {16'h0000, q.addr_c};
      OFS_OSTB:    rd_word = {19'h0_0000, q.ostb};
      OFS_OPA_LO:  rd_word = q.opa[31:0];
      OFS_OPA_HI:  rd_word = {12'h000, q.opa[WORD_W-1:32]};
      OFS_OPB_LO:  rd_word = q.opb[31:0];
      OFS_OPB_HI:  rd_word = {12'h000, q.opb[WORD_W-1:32]};
      OFS_SEQ:     rd_word = {16'h0000, q.seq};
      OFS_STATUS:  rd_word = {26'h000_0000, q.at_first, q.sub_vld, q.branched,
                              (q.st == S_KWAIT), q.halted, (q.st != S_IDLE)};
      OFS_SUBCALL: rd_word = {15'h0000, q.sub_vld, q.sub_addr};
      OFS_SENT_LO: rd_word = q.sent[31:0];
      OFS_SENT_HI: rd_word = {12'h000, q.sent[WORD_W-1:32]};
      OFS_SEARCH:  rd_word = {16'h0000, MAX_SBUF'(q.filled)};
      OFS_KEYSEL:  rd_word = {27'h000_0000, q.keysel};
      OFS_KEY_LO:  rd_word = ksel_ok ? q.keys[ksel_idx][q.keysel[KEYSEL_KEY_BIT]][31:0] : 32'h0000_0000;
      OFS_KEY_HI:  rd_word = ksel_ok ? {12'h000, q.keys[ksel_idx][q.keysel[KEYSEL_KEY_BIT]][WORD_W-1:32]}
                                     : 32'h0000_0000;
      default:     hit = 1'b0;
    endcase
  end

  always_comb begin
    d            = q;
    d.pready     = psel && penable && !q.pready;
    d.pslverr    = psel && penable && !q.pready && !hit;
    d.prdata     = (psel && penable && !q.pready && !pwrite) ? rd_word : 32'h0000_0000;
    d.print_vld  = 1'b0;
    d.rewind_vld = 1'b0;
    d.start_prev = start_button;
    d.setup_prev = setup_button;
    take         = 1'b0;
    stop_now     = 1'b0;

    // Register writes; operand and sequence fields locked while an order runs
    if (wr_en && hit) begin
      case (paddr)
        OFS_CTRL: begin
          if (pwdata[CTRL_START_BIT] && q.st == S_IDLE) begin
            d.op       = pwdata[3:0];
            d.st       = S_EXEC;
            d.branched = 1'b0;
          end
        end
        OFS_ADDR_A:  if (q.st == S_IDLE) d.addr_a = pwdata[ADDR_W-1:0];
        OFS_ADDR_B:  if (q.st == S_IDLE) d.addr_b = pwdata[ADDR_W-1:0];
        OFS_ADDR_C:  if (q.st == S_IDLE) d.addr_c = pwdata[ADDR_W-1:0];
        OFS_OSTB:    if (q.st == S_IDLE) d.ostb = pwdata[OSTB_W-1:0];
        OFS_OPA_LO:  if (q.st == S_IDLE) d.opa[31:0] = pwdata;
        OFS_OPA_HI:  if (q.st == S_IDLE) d.opa[WORD_W-1:32] = pwdata[HI_W-1:0];
        OFS_OPB_LO:  if (q.st == S_IDLE) d.opb[31:0] = pwdata;
        OFS_OPB_HI:  if (q.st == S_IDLE) d.opb[WORD_W-1:32] = pwdata[HI_W-1:0];
        OFS_SEQ:     if (q.st == S_IDLE) d.seq = pwdata[ADDR_W-1:0];
        OFS_SEARCH: begin
          // Issuing a search empties the buffer until its keys arrive
          d.pending = q.pending | pwdata[NUM_SBUF-1:0];
          d.filled  = q.filled & ~pwdata[NUM_SBUF-1:0];
        end
        OFS_KEYSEL:  d.keysel = pwdata[4:0];
        OFS_KEY_LO: begin
          if (ksel_ok) d.keys[ksel_idx][q.keysel[KEYSEL_KEY_BIT]][31:0] = pwdata;
        end
        OFS_KEY_HI: begin
          if (ksel_ok) begin
            d.keys[ksel_idx][q.keysel[KEYSEL_KEY_BIT]][WORD_W-1:32] = pwdata[HI_W-1:0];
            // Second key high half closes the search on that buffer
            if (q.keysel[KEYSEL_KEY_BIT]) begin
              d.filled[ksel_idx]  = 1'b1;
              d.pending[ksel_idx] = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // Reading the subcall register clears its flag; a new call below wins
    if (rd_en && paddr == OFS_SUBCALL) d.sub_vld = 1'b0;

    case (q.st)
      S_IDLE: ;
      S_EXEC: begin
        d.st = S_IDLE;
        case (q.op)
          OP_NUMERIC_LE: take = num_lt || num_eq;
          OP_NUMERIC_NE: take = !num_eq;
          OP_ALPHA_LE:   take = alp_lt || alp_eq;
          OP_ALPHA_NE:   take = !alp_eq;
          OP_FIRST_KEY, OP_SECOND_KEY: begin
            if (buf_ok && q.pending[buf_idx]) begin
              d.st = S_KWAIT;
            end else begin
              if (buf_ok && q.filled[buf_idx]) d.opa = q.keys[buf_idx][q.op == OP_SECOND_KEY];
              d.st = S_KCMP;
            end
          end
          OP_PRINT_ALPHA, OP_PRINT_NUMERIC: begin
            d.print_vld   = 1'b1;
            d.print_alpha = (q.op == OP_PRINT_ALPHA);
            d.print_word  = q.opa;
            if (q.addr_b != ADDR_VOID) d.seq = q.addr_b;
            if (q.addr_c != ADDR_VOID) begin
              d.sub_addr = q.addr_c;
              d.sub_vld  = 1'b1;
            end
          end
          OP_COND_HALT: begin
            // Switch levels are read only in this cycle
            if (q.ostb[OSTB_HALT]) begin
              stop_now = 1'b1;
            end else if (!q.ostb[OSTB_PROCEED]) begin
              case (stop_switch)
                SW_STOP:    stop_now = 1'b1;
                SW_COMPARE: stop_now = |(q.ostb[OSTB_BRK_LSB +: NUM_BRK] & brk_switch);
                default:    stop_now = 1'b0;
              endcase
            end
            if (stop_now) begin
              d.st         = S_HALT;
              d.halted     = 1'b1;
              d.setup_seen = 1'b0;
            end else begin
              d.sub_addr = q.addr_c;
              d.sub_vld  = 1'b1;
            end
          end
          OP_JUMP_SUBCALL: begin
            d.seq      = q.addr_b;
            d.sub_addr = q.addr_c;
            d.sub_vld  = 1'b1;
          end
          OP_BRANCH_RETURN: begin
            // Sequence register already points one past this order
            d.opa      = {OP_JUMP_SUBCALL, ADDR_VOID, q.seq, ADDR_VOID};
            d.seq      = q.addr_b;
            d.sub_addr = q.addr_c;
            d.sub_vld  = 1'b1;
          end
          OP_TAPE_REWIND: begin
            d.rewind_vld  = 1'b1;
            d.rewind_unit = q.addr_a[7:0];
            d.at_first    = 1'b1;
          end
          default: ;
        endcase
        if (take) begin
          d.seq      = q.addr_c;
          d.branched = 1'b1;
        end
      end
      S_KWAIT: begin
        if (!q.pending[buf_idx]) begin
          if (q.filled[buf_idx]) d.opa = q.keys[buf_idx][q.op == OP_SECOND_KEY];
          d.st = S_KCMP;
        end
      end
      S_KCMP: begin
        d.st   = S_IDLE;
        d.sent = q.opa[SENT_IDX] ? q.opa : PASS_WORD;
        if (q.op == OP_FIRST_KEY) take = !alp_lt;
        else take = alp_lt || alp_eq;
        if (take) begin
          d.seq      = q.addr_c;
          d.branched = 1'b1;
        end
      end
      S_HALT: begin
        if (setup_rise) d.setup_seen = 1'b1;
        if (start_rise) begin
          d.st     = S_IDLE;
          d.halted = 1'b0;
          if (!q.setup_seen) begin
            d.sub_addr = q.addr_c;
            d.sub_vld  = 1'b1;
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q     <= '0;
      q.st  <= S_IDLE;
      q.seq <= SEQ_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign halted       = q.halted;
  assign print_valid  = q.print_vld;
  assign print_alpha  = q.print_alpha;
  assign print_word   = q.print_word;
  assign rewind_valid = q.rewind_vld;
  assign rewind_unit  = q.rewind_unit;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered in one cycle");
  zero_equal_a: assert property ((q.opa[MAG_W-1:0] == '0) && (q.opb[MAG_W-1:0] == '0) |-> num_eq)
    else $error("Signed zeros not equal numerically");
  num_le_take_a: assert property (q.st == S_EXEC && q.op == OP_NUMERIC_LE && (num_lt || num_eq)
                                  |=> q.seq == $past(q.addr_c) && q.branched)
    else $error("Numeric less-or-equal did not branch");
  num_le_hold_a: assert property (q.st == S_EXEC && q.op == OP_NUMERIC_LE && !num_lt && !num_eq
                                  |=> $stable(q.seq))
    else $error("Numeric less-or-equal changed sequence");
  num_ne_take_a: assert property (q.st == S_EXEC && q.op == OP_NUMERIC_NE
                                  |=> q.branched == !$past(num_eq))
    else $error("Numeric inequality branch wrong");
  alpha_ne_a: assert property (q.st == S_EXEC && q.op == OP_ALPHA_NE && q.opa != q.opb |=> q.seq == $past(q.addr_c))
    else $error("Alphabetic inequality did not branch");
  key_stall_a: assert property (q.st == S_EXEC && (q.op == OP_FIRST_KEY || q.op == OP_SECOND_KEY) && buf_ok
                                && q.pending[buf_idx] |=> q.st == S_KWAIT)
    else $error("Key compare did not stall");
  key_skip_a: assert property (q.st == S_EXEC && q.op == OP_FIRST_KEY && buf_ok && !q.pending[buf_idx]
                               && !q.filled[buf_idx] |=> q.st == S_KCMP && $stable(q.opa))
    else $error("Unfilled buffer still copied");
  sentinel_store_a: assert property (q.st == S_KCMP |=> q.sent == ($past(q.opa[SENT_IDX]) ? $past(q.opa) : PASS_WORD))
    else $error("Sentinel register wrong");
  forced_halt_a: assert property (q.st == S_EXEC && q.op == OP_COND_HALT && q.ostb[OSTB_HALT]
                                  |=> halted ##1 halted || start_rise)
    else $error("Forced stop did not halt");
  return_store_a: assert property (q.st == S_EXEC && q.op == OP_BRANCH_RETURN
                                   |=> q.opa[A_LSB-1:B_LSB] == $past(q.seq) && q.seq == $past(q.addr_b)
                                   && q.sub_addr == $past(q.addr_c))
    else $error("Branch-return store wrong");
  rewind_first_a: assert property (q.st == S_EXEC && q.op == OP_TAPE_REWIND |=> rewind_valid && q.at_first)
    else $error("Rewind did not position first block");

  key_wait_c: cover property (q.st == S_KWAIT ##[1:20] q.st == S_KCMP);
  halt_resume_c: cover property (q.st == S_HALT ##[1:50] q.st == S_IDLE);
  sentinel_seen_c: cover property (q.st == S_KCMP && q.opa[SENT_IDX]);

endmodule // cbco_exec

// file: dv/cbco_console.sv
// Console model: switches held static, start pressed a few cycles after a halt.
// Assumes the executor's halted level and a shared synchronous reset.
`timescale 1ns/1ps
module cbco_console (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       halted,
  output logic [1:0]      stop_switch,
  output logic [9:0]      brk_switch,
  output logic            start_button,
  output logic            setup_button
);
  import cbco_pkg::*;
  logic [2:0] wait_q;
  // Static switches, only switch 1 on
  assign stop_switch  = SW_COMPARE;
  assign brk_switch   = 10'h001;
  assign setup_button = 1'b0;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wait_q       <= 3'h0;
      start_button <= 1'b0;
    end else begin
      wait_q       <= halted ? wait_q + 3'(wait_q != 3'h7) : 3'h0;
      start_button <= (wait_q == 3'h4);
    end
  end
endmodule // cbco_console

// file: dv/compare_branch_control_orders_tb.sv
// Bench for the order executor: APB master tasks and order sequences.
// Assumes the console model answers every halt with a start press.
`timescale 1ns/1ps
module compare_branch_control_orders_tb;
  import cbco_pkg::*;
  logic        clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, last_err, halted, start_button, setup_button;
  logic [1:0]  stop_switch;
  logic [9:0]  brk_switch;
  logic        print_valid, print_alpha, rewind_valid, saw;
  logic [51:0] print_word;
  logic [7:0]  rewind_unit;
  int          err_total = 0, checks = 0, prints = 0, rewinds = 0;
  always #12.5 clk_sys = ~clk_sys;
  // One-cycle pulses counted so that later compares can see them
  always @(posedge clk_sys) begin
    prints  <= prints + int'(print_valid === 1'b1);
    rewinds <= rewinds + int'(rewind_valid === 1'b1);
  end
  cbco_exec #(.NUM_SBUF(10)) uut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_switch(stop_switch), .brk_switch(brk_switch),
    .start_button(start_button), .setup_button(setup_button), .halted(halted),
    .print_valid(print_valid), .print_alpha(print_alpha), .print_word(print_word),
    .rewind_valid(rewind_valid), .rewind_unit(rewind_unit));
  cbco_console console (.clk_sys(clk_sys), .srst(srst), .halted(halted), .stop_switch(stop_switch),
    .brk_switch(brk_switch), .start_button(start_button), .setup_button(setup_button));
  task automatic tally_and_finish;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk_sys) penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
    if (n >= 40) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task automatic launch(input logic [3:0] op, input logic [15:0] a, b, c);
    apb(1, OFS_ADDR_A, {16'h0000, a}); apb(1, OFS_ADDR_B, {16'h0000, b});
    apb(1, OFS_ADDR_C, {16'h0000, c}); apb(1, OFS_CTRL, {23'h0, 1'b1, 4'h0, op});
  endtask
  task automatic settle;
    int n;
    n = 0;
    do begin
      apb(0, OFS_STATUS, 32'h0000_0000);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task automatic run(input logic [3:0] op, input logic [15:0] a, b, c);
    launch(op, a, b, c);
    settle;
  endtask
  // Sequence preset to 0100, then the order, then the sequence read back
  task automatic order(input logic [3:0] op, input logic [15:0] b, input logic [15:0] exp);
    apb(1, OFS_SEQ, 32'h0000_0100);
    run(op, 16'h0010, b, 16'h0321);
    apb(0, OFS_SEQ, 32'h0000_0000); chk("seq", rd, {16'h0000, exp});
  endtask
  task automatic conditional_halt_order(input logic [12:0] bits, input logic exp);
    apb(1, OFS_OSTB, {19'h0, bits});
    launch(OP_COND_HALT, 16'h0000, 16'h0000, 16'h0444);
    saw = 1'b0;
    repeat (12) @(posedge clk_sys) saw |= halted;
    chk("halt", {31'h0, saw}, {31'h0, exp});
    apb(0, OFS_SUBCALL, 32'h0000_0000);
    // Proceeding subcalls C as well, so both outcomes leave the same call
    chk("subcall", rd, 32'h0001_0444);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    apb(0, OFS_STATUS, 32'h0000_0000); chk("status", rd, 32'h0000_0000);
    apb(0, 8'h7C, 32'h0000_0000); chk("slverr", {31'h0, last_err}, 32'h1);
    // Plus zero at A, minus zero at B
    apb(1, OFS_OPA_LO, 32'h0000_0000); apb(1, OFS_OPA_HI, 32'h0000_0000);
    apb(1, OFS_OPB_LO, 32'h0000_0000); apb(1, OFS_OPB_HI, 32'h0000_1000);
    order(OP_NUMERIC_LE, 16'h0000, 16'h0321);
    order(OP_NUMERIC_NE, 16'h0000, 16'h0100);
    order(OP_ALPHA_NE, 16'h0000, 16'h0321);
    order(OP_NO_OP, 16'h0000, 16'h0100);
    // Only bit 49 of B set
    apb(1, OFS_OPB_HI, 32'h0001_0000);
    order(OP_NUMERIC_NE, 16'h0000, 16'h0100);
    order(OP_ALPHA_LE, 16'h0000, 16'h0321);
    // Buffer 0 never searched: old A kept, 0x77 below B
    apb(1, OFS_OPA_LO, 32'h0000_0077);
    order(OP_FIRST_KEY, 16'h0000, 16'h0100);
    apb(0, OFS_OPA_LO, 32'h0000_0000); chk("keep_a", rd, 32'h0000_0077);
    // Search pending on buffer 0: the order waits for the second key's high half
    apb(1, OFS_SEARCH, 32'h0000_0001);
    apb(1, OFS_SEQ, 32'h0000_0100);
    launch(OP_FIRST_KEY, 16'h0010, 16'h0000, 16'h0321);
    apb(0, OFS_STATUS, 32'h0000_0000); chk("key_wait", {31'h0, rd[ST_KEY_WAIT]}, 32'h1);
    apb(1, OFS_KEYSEL, 32'h0000_0000); apb(1, OFS_KEY_LO, 32'h0000_0005);
    apb(1, OFS_KEY_HI, 32'h0008_0000); apb(1, OFS_KEYSEL, 32'h0000_0010);
    apb(1, OFS_KEY_HI, 32'h0000_0000);
    settle;
    apb(0, OFS_SEQ, 32'h0000_0000); chk("seq", rd, 32'h0000_0321);
    apb(0, OFS_OPA_LO, 32'h0000_0000); chk("key_a", rd, 32'h0000_0005);
    apb(0, OFS_SENT_HI, 32'h0000_0000); chk("sentinel", rd, 32'h0008_0000);
    order(OP_SECOND_KEY, 16'h0000, 16'h0321);
    apb(0, OFS_SENT_HI, 32'h0000_0000); chk("pass_word", rd, 32'h0000_0000);
    order(OP_JUMP_SUBCALL, 16'h0222, 16'h0222);
    apb(1, OFS_OPA_LO, 32'h1234_5678);
    order(OP_PRINT_ALPHA, 16'h0777, 16'h0777);
    chk("print_alpha", {31'h0, print_alpha}, 32'h1);
    chk("print_word", print_word[31:0], 32'h1234_5678);
    order(OP_PRINT_NUMERIC, 16'h0000, 16'h0100);
    chk("print_numeric", {31'h0, print_alpha}, 32'h0);
    chk("prints", prints, 32'h2);
    conditional_halt_order(13'h0001, 1'b1);
    conditional_halt_order(13'h0004, 1'b1);
    conditional_halt_order(13'h0008, 1'b0);
    conditional_halt_order(13'h0002, 1'b0);
    apb(1, OFS_SEQ, 32'h0000_0100);
    run(OP_BRANCH_RETURN, 16'h0050, 16'h0200, 16'h0300);
    apb(0, OFS_OPA_LO, 32'h0000_0000); chk("return", rd, 32'h0100_0000);
    apb(0, OFS_SEQ, 32'h0000_0000); chk("seq", rd, 32'h0000_0200);
    apb(0, OFS_SUBCALL, 32'h0000_0000); chk("subcall", rd, 32'h0001_0300);
    run(OP_TAPE_REWIND, 16'h0023, 16'h0000, 16'h0000);
    chk("first", {31'h0, rd[ST_AT_FIRST]}, 32'h1);
    chk("unit", {24'h0, rewind_unit}, 32'h0000_0023);
    chk("rewinds", rewinds, 32'h1);
    tally_and_finish;
  end
endmodule // compare_branch_control_orders_tb
